/* File: bfci_pkg.sv */
package bfci_pkg;
    // ------------------------------------------------------------
    // widths
    // ------------------------------------------------------------
    localparam int ADDR_W = 18;
    localparam int DATA_W = 8;
    // ------------------------------------------------------------
    // command codes written to the device command latch
    // ------------------------------------------------------------
    localparam logic [7:0] CMD_READ = 8'h00;
    localparam logic [7:0] CMD_SIG = 8'h90;
    localparam logic [7:0] CMD_ERASE = 8'h20;
    localparam logic [7:0] CMD_ERASE_CHECK = 8'ha0;
    localparam logic [7:0] CMD_PROGRAM = 8'h40;
    localparam logic [7:0] CMD_PROGRAM_CHECK = 8'hc0;
    localparam logic [7:0] CMD_ABORT = 8'hff;
    // ------------------------------------------------------------
    // signature locations
    // ------------------------------------------------------------
    localparam logic [17:0] SIG_MAKER_LOC = 18'h00000;
    localparam logic [17:0] SIG_PART_LOC = 18'h00001;
    // ------------------------------------------------------------
    // host operation codes on the user port
    // ------------------------------------------------------------
    localparam logic [2:0] OP_READ = 3'h0;
    localparam logic [2:0] OP_WRITE = 3'h1;
    localparam logic [2:0] OP_SIG = 3'h2;
    localparam logic [2:0] OP_ERASE = 3'h3;
    localparam logic [2:0] OP_ERASE_CHECK = 3'h4;
    localparam logic [2:0] OP_PROGRAM = 3'h5;
    localparam logic [2:0] OP_PROGRAM_CHECK = 3'h6;
    localparam logic [2:0] OP_ABORT = 3'h7;
    // ------------------------------------------------------------
    // bus cycle timing, counts of ref_clk at 40 mhz
    // ------------------------------------------------------------
    localparam int CLK_NS = 25;
    localparam int SETUP_NS = 50;
    localparam int STROBE_NS = 100;
    localparam int ACCESS_NS = 150;
    localparam int HOLD_NS = 50;
    localparam logic [3:0] SETUP_CYC = 4'((SETUP_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [3:0] STROBE_CYC =
        4'((STROBE_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [3:0] ACCESS_CYC =
        4'((ACCESS_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [3:0] HOLD_CYC = 4'((HOLD_NS + CLK_NS - 1) / CLK_NS);
    // ------------------------------------------------------------
    // one bus cycle phases
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        BFCI_IDLE, BFCI_SETUP, BFCI_STROBE, BFCI_HOLD, BFCI_DONE
    } bfci_phase_t;
endpackage

/* File: bfci_cyc_if.sv */
`timescale 1ns/10ps
`default_nettype none
// ------------------------------------------------------------
// link between sequencer and the bus cycle engine
// ------------------------------------------------------------
interface bfci_cyc_if;
    logic start;
    logic is_write;
    logic [17:0] addr;
    logic [7:0] wdata;
    logic done;
    logic [7:0] rdata;
    modport seq (output start, is_write, addr, wdata, input done, rdata);
    modport eng (input start, is_write, addr, wdata, output done, rdata);
endinterface
`default_nettype wire

/* File: bfci_bus_cycle.sv */
`timescale 1ns/10ps
`default_nettype none
// one asynchronous memory read or write cycle on the device pins
module bfci_bus_cycle (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic clk_en,
    bfci_cyc_if.eng cyc,
    input wire logic [7:0] dq_in,
    output logic [17:0] addr_q,
    output logic [7:0] dq_out_q,
    output logic dq_oe_b_q,
    output logic chip_sel_b_q,
    output logic out_gate_b_q,
    output logic wr_strobe_b_q
);
    bfci_pkg::bfci_phase_t ph_q;
    logic [3:0] cnt_q;
    logic wr_q;
    logic [7:0] s1_q;
    logic [7:0] s2_q;
    logic [7:0] rd_q;
    logic done_q;
    wire cnt_end = (cnt_q == 4'h0);

    assign cyc.done = done_q;
    assign cyc.rdata = rd_q;

    // data pins pass two flops before use
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            s1_q <= 8'h00;
            s2_q <= 8'h00;
        end else if (clk_en) begin
            s1_q <= dq_in;
            s2_q <= s1_q;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            ph_q <= bfci_pkg::BFCI_IDLE;
            cnt_q <= 4'h0;
            wr_q <= 1'b0;
            rd_q <= 8'h00;
            done_q <= 1'b0;
            addr_q <= 18'h00000;
            dq_out_q <= 8'h00;
            dq_oe_b_q <= 1'b1;
            chip_sel_b_q <= 1'b1;
            out_gate_b_q <= 1'b1;
            wr_strobe_b_q <= 1'b1;
        end else if (clk_en) begin
            done_q <= 1'b0;
            case (ph_q)
                bfci_pkg::BFCI_IDLE: begin
                    if (cyc.start) begin
                        // gate stays high during writes so pins never fight
                        addr_q <= cyc.addr;
                        dq_out_q <= cyc.wdata;
                        wr_q <= cyc.is_write;
                        chip_sel_b_q <= 1'b0;
                        cnt_q <= bfci_pkg::SETUP_CYC;
                        ph_q <= bfci_pkg::BFCI_SETUP;
                    end
                end
                bfci_pkg::BFCI_SETUP: begin
                    cnt_q <= cnt_q - 4'h1;
                    if (cnt_end) begin
                        if (wr_q) begin
                            // address is taken by the device on this edge
                            wr_strobe_b_q <= 1'b0;
                            dq_oe_b_q <= 1'b0;
                            cnt_q <= bfci_pkg::STROBE_CYC;
                        end else begin
                            out_gate_b_q <= 1'b0;
                            cnt_q <= bfci_pkg::ACCESS_CYC;
                        end
                        ph_q <= bfci_pkg::BFCI_STROBE;
                    end
                end
                bfci_pkg::BFCI_STROBE: begin
                    cnt_q <= cnt_q - 4'h1;
                    if (cnt_end) begin
                        // data is taken by the device on the rising strobe
                        wr_strobe_b_q <= 1'b1;
                        out_gate_b_q <= 1'b1;
                        rd_q <= s2_q;
                        cnt_q <= bfci_pkg::HOLD_CYC;
                        ph_q <= bfci_pkg::BFCI_HOLD;
                    end
                end
                bfci_pkg::BFCI_HOLD: begin
                    cnt_q <= cnt_q - 4'h1;
                    if (cnt_end) begin
                        dq_oe_b_q <= 1'b1;
                        chip_sel_b_q <= 1'b1;
                        done_q <= 1'b1;
                        ph_q <= bfci_pkg::BFCI_DONE;
                    end
                end
                bfci_pkg::BFCI_DONE: ph_q <= bfci_pkg::BFCI_IDLE;
                default: ph_q <= bfci_pkg::BFCI_IDLE;
            endcase
        end
    end
endmodule
`default_nettype wire

/* File: bfci_host.sv */
`timescale 1ns/10ps
`default_nettype none
// ------------------------------------------------------------
// Overview of operation
// ------------------------------------------------------------
// Overview of operation
// - data only with select and gate low
// - signature mode persists until new command
// - strobe low under select, address/data edges
// - after abort, write next command
// - erase needs two consecutive 20h writes
// - 40h arms, next write programs
// - two ffh writes cancel armed operation
// - a0h ends erase, stages margin check
module bfci_host (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic clk_en,
    // user request port
    input wire logic req_valid,
    input wire logic [2:0] req_op,
    input wire logic [17:0] req_addr,
    input wire logic [7:0] req_data,
    output logic req_ready_q,
    output logic rsp_valid_q,
    output logic [7:0] rsp_data_q,
    output logic supply_on_q,
    // device pins
    output logic [17:0] mem_addr_q,
    input wire logic [7:0] mem_dq_in,
    output logic [7:0] mem_dq_out_q,
    output logic mem_dq_oe_b_q,
    output logic chip_sel_b_q,
    output logic out_gate_b_q,
    output logic wr_strobe_b_q,
    output logic program_supply_high_q,
    output logic signature_high_voltage_q
);
    // ------------------------------------------------------------
    // sequencer state
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        BFCI_S_IDLE, BFCI_S_W1, BFCI_S_W2, BFCI_S_RD, BFCI_S_RSP
    } bfci_seq_t;

    bfci_seq_t st_q;
    logic [2:0] op_q;
    logic [17:0] ad_q;
    logic [7:0] dt_q;
    logic start_q;
    bfci_seq_t st_d;
    logic start_d;

    bfci_cyc_if cyc ();

    // first command code of each operation
    function automatic logic [7:0] bfci_first_code(input logic [2:0] op);
        case (op)
            bfci_pkg::OP_SIG: bfci_first_code = bfci_pkg::CMD_SIG;
            bfci_pkg::OP_ERASE: bfci_first_code = bfci_pkg::CMD_ERASE;
            bfci_pkg::OP_ERASE_CHECK:
                bfci_first_code = bfci_pkg::CMD_ERASE_CHECK;
            bfci_pkg::OP_PROGRAM: bfci_first_code = bfci_pkg::CMD_PROGRAM;
            bfci_pkg::OP_PROGRAM_CHECK:
                bfci_first_code = bfci_pkg::CMD_PROGRAM_CHECK;
            bfci_pkg::OP_ABORT: bfci_first_code = bfci_pkg::CMD_ABORT;
            default: bfci_first_code = bfci_pkg::CMD_READ;
        endcase
    endfunction

    // ------------------------------------------------------------
    // decoding of the latched operation
    // ------------------------------------------------------------
    wire is_wr = (op_q == bfci_pkg::OP_WRITE);
    wire two_wr = (op_q == bfci_pkg::OP_ERASE) ||
                  (op_q == bfci_pkg::OP_PROGRAM) ||
                  (op_q == bfci_pkg::OP_ABORT);
    wire has_rd = (op_q == bfci_pkg::OP_SIG) ||
                  (op_q == bfci_pkg::OP_ERASE_CHECK) ||
                  (op_q == bfci_pkg::OP_PROGRAM_CHECK);
    // second write: program sends target address and byte, others repeat
    wire [7:0] w2_data = (op_q == bfci_pkg::OP_PROGRAM) ? dt_q :
                         bfci_first_code(op_q);
    // signature read goes to location 0/1 with other address bits low
    wire [17:0] sig_ad = ad_q[0] ? bfci_pkg::SIG_PART_LOC :
                         bfci_pkg::SIG_MAKER_LOC;
    wire [17:0] rd_ad = (op_q == bfci_pkg::OP_SIG) ? sig_ad : ad_q;
    // erase check carries its address on the command write itself
    wire [17:0] w1_ad = (op_q == bfci_pkg::OP_ERASE_CHECK) ? ad_q :
                        (op_q == bfci_pkg::OP_SIG) ? sig_ad :
                        18'h00000;
    wire [7:0] w1_data = is_wr ? dt_q : bfci_first_code(op_q);

    assign cyc.start = start_q;
    assign cyc.is_write = (st_q == BFCI_S_W1) || (st_q == BFCI_S_W2);
    assign cyc.addr = (st_q == BFCI_S_W1) ? w1_ad :
                      (st_q == BFCI_S_W2) ? ad_q : rd_ad;
    assign cyc.wdata = (st_q == BFCI_S_W2) ? w2_data : w1_data;

    bfci_bus_cycle u_cycle (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .clk_en(clk_en),
        .cyc(cyc.eng),
        .dq_in(mem_dq_in),
        .addr_q(mem_addr_q),
        .dq_out_q(mem_dq_out_q),
        .dq_oe_b_q(mem_dq_oe_b_q),
        .chip_sel_b_q(chip_sel_b_q),
        .out_gate_b_q(out_gate_b_q),
        .wr_strobe_b_q(wr_strobe_b_q)
    );

    // ------------------------------------------------------------
    // request port
    // ------------------------------------------------------------
    wire in_idle = (st_q == BFCI_S_IDLE);
    wire take = in_idle && req_valid && req_ready_q;
    wire is_read_req = (req_op == bfci_pkg::OP_READ);
    wire rd_fin = (st_q == BFCI_S_RD) && cyc.done;

    // ready is low outside idle, so a held request is never taken twice
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            req_ready_q <= 1'b0;
        end else if (clk_en) begin
            req_ready_q <= in_idle && !take;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            op_q <= bfci_pkg::OP_READ;
            ad_q <= 18'h00000;
            dt_q <= 8'h00;
        end else if (clk_en && take) begin
            op_q <= req_op;
            ad_q <= req_addr;
            dt_q <= req_data;
        end
    end

    // ------------------------------------------------------------
    // device supplies
    // ------------------------------------------------------------
    // supply stays high through the whole command sequence; plain reads
    // drop it so the device falls back to a read-only memory. the high
    // identifier level is never raised: codes are read via the latch,
    // which keeps high voltage off the address lines
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            program_supply_high_q <= 1'b0;
            supply_on_q <= 1'b0;
            signature_high_voltage_q <= 1'b0;
        end else if (clk_en) begin
            supply_on_q <= program_supply_high_q;
            if (take) begin
                program_supply_high_q <= !is_read_req;
            end
        end
    end

    // ------------------------------------------------------------
    // response to the user
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            rsp_valid_q <= 1'b0;
            rsp_data_q <= 8'h00;
        end else if (clk_en) begin
            rsp_valid_q <= (st_q == BFCI_S_RSP);
            if (rd_fin) begin
                rsp_data_q <= cyc.rdata;
            end
        end
    end

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    always_comb begin
        st_d = st_q;
        start_d = 1'b0;
        case (st_q)
            BFCI_S_IDLE: begin
                if (take) begin
                    // plain reads need no command write
                    start_d = 1'b1;
                    st_d = is_read_req ? BFCI_S_RD : BFCI_S_W1;
                end
            end
            BFCI_S_W1: begin
                if (cyc.done) begin
                    start_d = two_wr || has_rd;
                    st_d = two_wr ? BFCI_S_W2 :
                           has_rd ? BFCI_S_RD : BFCI_S_RSP;
                end
            end
            BFCI_S_W2: begin
                if (cyc.done) begin
                    st_d = BFCI_S_RSP;
                end
            end
            BFCI_S_RD: begin
                if (cyc.done) begin
                    st_d = BFCI_S_RSP;
                end
            end
            BFCI_S_RSP: st_d = BFCI_S_IDLE;
            default: st_d = BFCI_S_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            st_q <= BFCI_S_IDLE;
            start_q <= 1'b0;
        end else if (clk_en) begin
            st_q <= st_d;
            start_q <= start_d;
        end
    end
endmodule
`default_nettype wire

/* File: bfci_host_properties.sv */
`timescale 1ns/10ps
`default_nettype none
// ------------------------------------------------------------
// pin protocol checks, plus response pulse and supply flag checks
// ------------------------------------------------------------
module bfci_host_properties (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic clk_en,
    input wire logic rsp_valid_q,
    input wire logic supply_on_q,
    input wire logic [17:0] mem_addr_q,
    input wire logic mem_dq_oe_b_q,
    input wire logic chip_sel_b_q,
    input wire logic out_gate_b_q,
    input wire logic wr_strobe_b_q,
    input wire logic program_supply_high_q,
    input wire logic signature_high_voltage_q
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    a_strobe_under_sel: assert property (
        !wr_strobe_b_q |-> !chip_sel_b_q)
        else $error("strobe low while deselected");
    a_gate_under_sel: assert property (
        !out_gate_b_q |-> !chip_sel_b_q)
        else $error("gate low while deselected");
    a_gate_no_drive: assert property (
        !out_gate_b_q |-> mem_dq_oe_b_q && wr_strobe_b_q)
        else $error("host drives data during read");
    a_strobe_supply: assert property (
        !wr_strobe_b_q |-> program_supply_high_q)
        else $error("write without program supply");
    a_strobe_len: assert property (
        $fell(wr_strobe_b_q) |-> !wr_strobe_b_q [*5])
        else $error("write strobe too short");
    a_data_at_rise: assert property (
        $rose(wr_strobe_b_q) |-> !mem_dq_oe_b_q && !chip_sel_b_q)
        else $error("data gone at strobe rise");
    a_addr_hold: assert property (
        !wr_strobe_b_q && !$past(wr_strobe_b_q) |-> $stable(mem_addr_q))
        else $error("address moved under strobe");
    a_sig_off: assert property (
        !signature_high_voltage_q)
        else $error("signature voltage raised");
    a_rsp_pulse: assert property (rsp_valid_q |=> !rsp_valid_q)
        else $error("response longer than one cycle");
    a_supply_copy: assert property (
        clk_en |=> supply_on_q == $past(program_supply_high_q))
        else $error("supply flag not a delayed copy");
endmodule
bind bfci_host bfci_host_properties u_props (.ref_clk(ref_clk), .rst_b(rst_b),
    .clk_en(clk_en), .rsp_valid_q(rsp_valid_q), .supply_on_q(supply_on_q),
    .mem_addr_q(mem_addr_q), .mem_dq_oe_b_q(mem_dq_oe_b_q),
    .chip_sel_b_q(chip_sel_b_q), .out_gate_b_q(out_gate_b_q),
    .wr_strobe_b_q(wr_strobe_b_q),
    .program_supply_high_q(program_supply_high_q),
    .signature_high_voltage_q(signature_high_voltage_q));
`default_nettype wire

/* File: bfci_flash_model.sv */
`timescale 1ns/10ps
`default_nettype none
// ------------------------------------------------------------
// behavioural flash device, 16 byte array
// ------------------------------------------------------------
module bfci_flash_model #(
    // codes are arbitrary
    parameter logic [7:0] MAKER_CODE = 8'h5a,
    parameter logic [7:0] PART_CODE = 8'h6b
) (
    input wire logic [17:0] addr,
    input wire logic [7:0] dq,
    input wire logic chip_sel_b,
    input wire logic out_gate_b,
    input wire logic wr_strobe_b,
    input wire logic vpp_on,
    input wire logic sig_hv,
    input wire logic vcc_low,
    output logic [7:0] dq_dev,
    output logic drive
);
    logic [7:0] arr [16];
    logic [7:0] cmd_q = 8'h00;
    logic [17:0] lat_q = 18'h0;
    logic [17:0] prog_loc_q = 18'h0;
    logic [17:0] erase_loc_q = 18'h0;
    logic wr_ok;
    logic sig_on;
    initial begin
        for (int i = 0; i < 16; i++) arr[i] = 8'h50 ^ 8'(i);
    end
    // a low logic supply locks the latch even with the program supply up
    assign wr_ok = !chip_sel_b && vpp_on && !vcc_low;
    always @(negedge wr_strobe_b) begin
        if (wr_ok) lat_q = addr;
    end
    // latch state survives deselect; only a write or a falling supply
    // moves it, both in one process so the latch has a single writer
    always @(negedge vpp_on or posedge wr_strobe_b) begin
        if (!vpp_on) begin
            cmd_q = 8'h00;
        end else if (wr_strobe_b && wr_ok) begin
            if (cmd_q == 8'h40) begin
                // an ffh byte leaves the array as is
                arr[lat_q[3:0]] = arr[lat_q[3:0]] & dq;
                prog_loc_q = lat_q;
                cmd_q = 8'h01;
            end else if (cmd_q == 8'h20 && dq == 8'h20) begin
                for (int i = 0; i < 16; i++) arr[i] = 8'hff;
                cmd_q = 8'h02;
            end else begin
                if (dq == 8'ha0) erase_loc_q = lat_q;
                cmd_q = dq;
            end
        end
    end
    assign sig_on = (sig_hv || cmd_q == 8'h90) &&
        addr[17:1] == 17'h0;
    assign drive = !chip_sel_b && !out_gate_b;
    assign dq_dev = sig_on ? (addr[0] ? PART_CODE : MAKER_CODE) :
        cmd_q == 8'ha0 ? arr[erase_loc_q[3:0]] :
        cmd_q == 8'hc0 ? arr[prog_loc_q[3:0]] : arr[addr[3:0]];
endmodule
`default_nettype wire

/* File: tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
// ------------------------------------------------------------
// host sequences against the device model
// ------------------------------------------------------------
module tb_top;
    logic ref_clk = 1'b0;
    logic rst_b = 1'b0;
    logic req_valid = 1'b0;
    logic [2:0] req_op = 3'h0;
    logic [17:0] req_addr = 18'h0;
    logic [7:0] req_data = 8'h00;
    logic vcc_low = 1'b0;
    logic req_ready_q, rsp_valid_q, supply_on_q, mem_dq_oe_b_q;
    logic [7:0] rsp_data_q, mem_dq_out_q, dq_dev, rd;
    logic [7:0] bus_last = 8'h00;
    logic [17:0] mem_addr_q;
    logic chip_sel_b_q, out_gate_b_q, wr_strobe_b_q, drive;
    logic program_supply_high_q, signature_high_voltage_q;
    wire logic [7:0] dq_wire;
    int error_cnt = 0;
    int tests_run = 0;
    int cyc = 0;
    // released bus shows the inverse of its last level
    assign dq_wire = !mem_dq_oe_b_q ? mem_dq_out_q :
        drive ? dq_dev : ~bus_last;
    bfci_host u_dut (.ref_clk(ref_clk), .rst_b(rst_b), .clk_en(1'b1),
        .req_valid(req_valid), .req_op(req_op), .req_addr(req_addr),
        .req_data(req_data), .req_ready_q(req_ready_q),
        .rsp_valid_q(rsp_valid_q), .rsp_data_q(rsp_data_q),
        .supply_on_q(supply_on_q), .mem_addr_q(mem_addr_q),
        .mem_dq_in(dq_wire), .mem_dq_out_q(mem_dq_out_q),
        .mem_dq_oe_b_q(mem_dq_oe_b_q), .chip_sel_b_q(chip_sel_b_q),
        .out_gate_b_q(out_gate_b_q), .wr_strobe_b_q(wr_strobe_b_q),
        .program_supply_high_q(program_supply_high_q),
        .signature_high_voltage_q(signature_high_voltage_q));
    bfci_flash_model u_flash (.addr(mem_addr_q), .dq(dq_wire),
        .chip_sel_b(chip_sel_b_q), .out_gate_b(out_gate_b_q),
        .wr_strobe_b(wr_strobe_b_q), .vpp_on(program_supply_high_q),
        .sig_hv(signature_high_voltage_q), .vcc_low(vcc_low),
        .dq_dev(dq_dev), .drive(drive));
    initial begin
        forever #12.5 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        if (!mem_dq_oe_b_q || drive) bus_last <= dq_wire;
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            error_cnt++;
            end_of_test();
        end
    end
    task automatic end_of_test();
        $display("errors %0d comparisons %0d", error_cnt, tests_run);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic do_op(input logic [2:0] op, input logic [17:0] a,
        input logic [7:0] d);
        int n;
        n = 0;
        while (req_ready_q !== 1'b1 && n < 200) begin
            @(negedge ref_clk);
            n++;
        end
        if (n >= 200) error_cnt++;
        req_op = op;
        req_addr = a;
        req_data = d;
        req_valid = 1'b1;
        @(negedge ref_clk);
        req_valid = 1'b0;
        n = 0;
        while (rsp_valid_q !== 1'b1 && n < 200) begin
            @(negedge ref_clk);
            n++;
        end
        if (n >= 200) error_cnt++;
        rd = rsp_data_q;
        @(negedge ref_clk);
    endtask
    task automatic sc_signature();
        do_op(bfci_pkg::OP_SIG, bfci_pkg::SIG_MAKER_LOC, 8'h00);
        check(rd, 8'h5a);
        do_op(bfci_pkg::OP_SIG, bfci_pkg::SIG_PART_LOC, 8'h00);
        check(rd, 8'h6b);
        do_op(bfci_pkg::OP_READ, 18'h2, 8'h00);
        check(rd, 8'h52);
    endtask
    task automatic sc_program();
        do_op(bfci_pkg::OP_PROGRAM, 18'h5, 8'h3c);
        do_op(bfci_pkg::OP_PROGRAM_CHECK, 18'h0, 8'h00);
        check(rd, 8'h14);
        do_op(bfci_pkg::OP_WRITE, 18'h0, bfci_pkg::CMD_READ);
        do_op(bfci_pkg::OP_READ, 18'h5, 8'h00);
        check(rd, 8'h14);
    endtask
    task automatic sc_lockout();
        // writes under lockout are lost, so the read sees the array
        vcc_low = 1'b1;
        do_op(bfci_pkg::OP_SIG, bfci_pkg::SIG_MAKER_LOC, 8'h00);
        check(rd, 8'h50);
        vcc_low = 1'b0;
    endtask
    task automatic sc_abort();
        // arm erase first: a repeated 20h instead of ffh would wipe it
        do_op(bfci_pkg::OP_WRITE, 18'h0, bfci_pkg::CMD_ERASE);
        do_op(bfci_pkg::OP_ABORT, 18'h7, 8'h00);
        do_op(bfci_pkg::OP_WRITE, 18'h0, bfci_pkg::CMD_READ);
        do_op(bfci_pkg::OP_READ, 18'h7, 8'h00);
        check(rd, 8'h57);
    endtask
    task automatic sc_erase();
        do_op(bfci_pkg::OP_ERASE, 18'h0, 8'h00);
        do_op(bfci_pkg::OP_ERASE_CHECK, 18'h5, 8'h00);
        check(rd, 8'hff);
        do_op(bfci_pkg::OP_READ, 18'h9, 8'h00);
        check(rd, 8'hff);
    endtask
    initial begin
        repeat (2) @(negedge ref_clk);
        rst_b = 1'b1;
        @(negedge ref_clk);
        sc_lockout();
        sc_signature();
        sc_program();
        sc_abort();
        sc_erase();
        end_of_test();
    end
endmodule
`default_nettype wire
